// ---- hdl/ncfg_map.svh ----
// Constants for the configuration loader and host-port select block
`ifndef NCFG_MAP_SVH
`define NCFG_MAP_SVH
// ==========================================================
// Sizes
`define NCFG_NREG 16
`define NCFG_AW 4
`define NCFG_DW 8
`define NCFG_NSLOT 2
`define NCFG_NDIV 8
// ==========================================================
// Register indices of the live set
`define NCFG_REG_CTRL 4'h0
`define NCFG_REG_PWR_IN 4'h1
`define NCFG_REG_PWR_OUT 4'h2
`define NCFG_REG_PWR_LOOP 4'h3
// Control register fields
`define NCFG_CTRL_HARDRST 0
`define NCFG_CTRL_COMMIT 1
// ==========================================================
// Reset values and counts
`define NCFG_ZERO8 8'h00
`define NCFG_ZERO4 4'h0
`define NCFG_ONES8 8'hff
`define NCFG_LAST_IDX 4'hf
`define NCFG_DIVRST_CYC 4'h8
`define NCFG_IMG_NONE 2'h0
`define NCFG_IMG_ONE 2'h1
`define NCFG_IMG_TWO 2'h2
`endif

// ---- hdl/ncfg_pkg.sv ----
// Types for the configuration loader block
package ncfg_pkg;
    typedef enum logic [2:0] {
        NCFG_ST_LOAD = 3'h0,
        NCFG_ST_DIVRST = 3'h1,
        NCFG_ST_RUN = 3'h2,
        NCFG_ST_COMMIT = 3'h3
    } ncfg_state_t;
endpackage

// ---- hdl/ncfg_sync.sv ----
// Two-flop synchroniser for pin inputs
`timescale 1ns/1ps
`default_nettype none
module ncfg_sync (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    input wire logic clkEn,
    // Data
    input wire logic din,
    output logic dout
);
    logic meta_q;
    // ==========================================================
    // Synchroniser, first stage read only by second
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            meta_q <= 1'b0;
            dout <= 1'b0;
        end else if (clkEn) begin
            meta_q <= din;
            dout <= meta_q;
        end
    end
endmodule
`default_nettype wire

// ---- hdl/ncfg_loader.sv ----
// Configuration loader, divider reset and host-port select
`timescale 1ns/1ps
`default_nettype none
`include "ncfg_map.svh"
module ncfg_loader import ncfg_pkg::*; (
    // Clock, reset, enable
    input wire logic clk,
    input wire logic rst_n,
    input wire logic clkEn,
    // Pins
    input wire logic external_reset_pin_n,
    input wire logic hostSelI2cPin,
    input wire logic spi3WirePin,
    // Register access from the serial target logic
    input wire logic regWrEn,
    input wire logic [`NCFG_AW-1:0] regAddr,
    input wire logic [`NCFG_DW-1:0] regWrData,
    output logic [`NCFG_DW-1:0] regRdData,
    // Non-volatile store write port from host logic
    input wire logic nvmWrEn,
    input wire logic [`NCFG_AW-1:0] nvmWrAddr,
    input wire logic [`NCFG_DW-1:0] nvmWrData,
    // Preprogrammed image present
    input wire logic factoryImage,
    // Status and control outputs
    output logic loadDone,
    output logic divReset,
    output logic i2cSelected,
    output logic spi3Wire,
    output logic [1:0] imagesUsed,
    output logic commitRefused,
    output logic [`NCFG_DW-1:0] pwrDownIn,
    output logic [`NCFG_DW-1:0] pwrDownOut,
    output logic [`NCFG_DW-1:0] pwrDownLoop
);
    typedef struct packed {
        ncfg_state_t st;
        logic [`NCFG_AW-1:0] idx;
        logic [3:0] cnt;
        logic [1:0] used;
        logic activeSlot;
        logic refused;
        logic selI2c;
        logic sel3w;
        logic selTaken;
        logic [`NCFG_DW-1:0] rd;
        logic [`NCFG_NREG*`NCFG_DW-1:0] live;
        logic [`NCFG_NREG*`NCFG_DW-1:0] stage;
        logic [`NCFG_NSLOT*`NCFG_NREG*`NCFG_DW-1:0] nvm;
    } ncfg_regs_t;

    ncfg_regs_t s_q;
    ncfg_regs_t s_d;
    logic rstPinSync;
    logic selSync;
    logic sel3Sync;
    logic hardRst;

    // ==========================================================
    // Pin synchronisers
    ncfg_sync uRstSync (.clk(clk), .rst_n(rst_n), .clkEn(clkEn),
        .din(external_reset_pin_n), .dout(rstPinSync));
    ncfg_sync uSelSync (.clk(clk), .rst_n(rst_n), .clkEn(clkEn),
        .din(hostSelI2cPin), .dout(selSync));
    ncfg_sync uSel3Sync (.clk(clk), .rst_n(rst_n), .clkEn(clkEn),
        .din(spi3WirePin), .dout(sel3Sync));

    // Hard reset bit in the control register
    assign hardRst = s_q.live[`NCFG_REG_CTRL*`NCFG_DW + `NCFG_CTRL_HARDRST];

    // ==========================================================
    // Next state
    always_comb begin
        s_d = s_q;
        s_d.rd = s_q.live[regAddr*`NCFG_DW +: `NCFG_DW];
        // Strap caught once at load end, after both sync stages have settled
        if (!s_q.selTaken && s_q.st == NCFG_ST_LOAD && s_q.idx == `NCFG_LAST_IDX) begin
            s_d.selI2c = selSync;
            s_d.sel3w = sel3Sync;
            s_d.selTaken = 1'b1;
        end
        // Writes to the staging image, committed later
        if (nvmWrEn && s_q.st == NCFG_ST_RUN) begin
            s_d.stage[nvmWrAddr*`NCFG_DW +: `NCFG_DW] = nvmWrData;
        end
        case (s_q.st)
            NCFG_ST_LOAD: begin
                if (factoryImage || s_q.used != `NCFG_IMG_NONE) begin
                    // Only the active slot is read, the other is never exposed
                    s_d.live[s_q.idx*`NCFG_DW +: `NCFG_DW] =
                        s_q.nvm[{s_q.activeSlot, s_q.idx}*`NCFG_DW +: `NCFG_DW];
                end else begin
                    // Blank store reads erased, so all blocks stay powered down
                    s_d.live[s_q.idx*`NCFG_DW +: `NCFG_DW] = `NCFG_ONES8;
                end
                s_d.idx = s_q.idx + 4'h1;
                if (s_q.idx == `NCFG_LAST_IDX) begin
                    s_d.st = NCFG_ST_DIVRST;
                    s_d.cnt = `NCFG_ZERO4;
                    // Self-clear so a stored hard-reset bit cannot loop
                    s_d.live[`NCFG_REG_CTRL*`NCFG_DW +: `NCFG_DW] = `NCFG_ZERO8;
                end
            end
            NCFG_ST_DIVRST: begin
                s_d.cnt = s_q.cnt + 4'h1;
                if (!rstPinSync) begin
                    // Pin still low: clear the count to zero so dividers are not let go early
                    s_d.cnt = `NCFG_ZERO4;
                end else if (s_q.cnt == `NCFG_DIVRST_CYC - 4'h1) begin
                    s_d.st = NCFG_ST_RUN;
                end
            end
            NCFG_ST_RUN: begin
                if (regWrEn) begin
                    s_d.live[regAddr*`NCFG_DW +: `NCFG_DW] = regWrData;
                end
                if (!rstPinSync || hardRst) begin
                    // Pin or bit gives the same divider reset as power-up
                    s_d.st = NCFG_ST_DIVRST;
                    s_d.cnt = `NCFG_ZERO4;
                    s_d.live[`NCFG_REG_CTRL*`NCFG_DW +: `NCFG_DW] = `NCFG_ZERO8;
                end else if (regWrEn && regAddr == `NCFG_REG_CTRL
                        && regWrData[`NCFG_CTRL_COMMIT]) begin
                    s_d.live[`NCFG_REG_CTRL*`NCFG_DW + `NCFG_CTRL_COMMIT] = 1'b0;
                    if (s_q.used == `NCFG_IMG_TWO) begin
                        s_d.refused = 1'b1;
                    end else begin
                        s_d.st = NCFG_ST_COMMIT;
                    end
                end
            end
            NCFG_ST_COMMIT: begin
                // First commit fills slot 1, second rewrites slot 0
                s_d.activeSlot = (s_q.used == `NCFG_IMG_NONE);
                s_d.used = s_q.used + 2'h1;
                if (s_q.used == `NCFG_IMG_NONE) begin
                    s_d.nvm[`NCFG_NREG*`NCFG_DW +: `NCFG_NREG*`NCFG_DW] = s_q.stage;
                end else begin
                    s_d.nvm[0 +: `NCFG_NREG*`NCFG_DW] = s_q.stage;
                end
                s_d.st = NCFG_ST_RUN;
            end
            default: begin
                s_d.st = NCFG_ST_LOAD;
            end
        endcase
    end

    // ==========================================================
    // State register; the store is a model held in flops, cleared here
    // only because real non-volatile cells have no reset in logic
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s_q <= '0;
        end else if (clkEn) begin
            s_q <= s_d;
        end
    end

    // ==========================================================
    // Outputs
    assign regRdData = s_q.rd;
    assign loadDone = (s_q.st == NCFG_ST_RUN) || (s_q.st == NCFG_ST_COMMIT);
    assign divReset = (s_q.st == NCFG_ST_LOAD) || (s_q.st == NCFG_ST_DIVRST);
    assign i2cSelected = s_q.selI2c;
    assign spi3Wire = s_q.sel3w & ~s_q.selI2c;
    assign imagesUsed = s_q.used;
    assign commitRefused = s_q.refused;
    assign pwrDownIn = s_q.live[`NCFG_REG_PWR_IN*`NCFG_DW +: `NCFG_DW];
    assign pwrDownOut = s_q.live[`NCFG_REG_PWR_OUT*`NCFG_DW +: `NCFG_DW];
    assign pwrDownLoop = s_q.live[`NCFG_REG_PWR_LOOP*`NCFG_DW +: `NCFG_DW];

    // ==========================================================
    // Checks
    sequence s_loadEnd;
        s_q.st == NCFG_ST_LOAD && s_q.idx == `NCFG_LAST_IDX;
    endsequence
    property p_loadThenDiv;
        @(posedge clk) disable iff (!rst_n)
        (s_loadEnd and clkEn) |=> s_q.st == NCFG_ST_DIVRST && divReset;
    endproperty
    a_loadThenDiv: assert property (p_loadThenDiv) else $error("no divider reset after load");
    property p_pinReset;
        @(posedge clk) disable iff (!rst_n)
        (clkEn && s_q.st == NCFG_ST_RUN && !rstPinSync) |=> divReset;
    endproperty
    a_pinReset: assert property (p_pinReset) else $error("pin reset ignored");
    property p_noOutEarly;
        @(posedge clk) disable iff (!rst_n)
        !loadDone |-> divReset;
    endproperty
    a_noOutEarly: assert property (p_noOutEarly) else $error("outputs before load");
    property p_maxTwo;
        @(posedge clk) disable iff (!rst_n)
        imagesUsed <= `NCFG_IMG_TWO;
    endproperty
    a_maxTwo: assert property (p_maxTwo) else $error("more than two images");
    property p_refuse;
        @(posedge clk) disable iff (!rst_n)
        (clkEn && imagesUsed == `NCFG_IMG_TWO && s_q.st == NCFG_ST_COMMIT) |-> 1'b0;
    endproperty
    a_refuse: assert property (p_refuse) else $error("third commit accepted");
    property p_commitSlot;
        @(posedge clk) disable iff (!rst_n)
        (clkEn && s_q.st == NCFG_ST_COMMIT) |=> s_q.activeSlot == (imagesUsed == `NCFG_IMG_ONE);
    endproperty
    a_commitSlot: assert property (p_commitSlot) else $error("old image still active");
    property p_selStable;
        @(posedge clk) disable iff (!rst_n)
        (s_q.selTaken && clkEn) |=> $stable(i2cSelected);
    endproperty
    a_selStable: assert property (p_selStable) else $error("port select changed");
    property p_spiOnly;
        @(posedge clk) disable iff (!rst_n)
        spi3Wire |-> !i2cSelected;
    endproperty
    a_spiOnly: assert property (p_spiOnly) else $error("3-wire with I2C");
    property p_divLen;
        @(posedge clk) disable iff (!rst_n)
        (clkEn && s_q.st == NCFG_ST_RUN && $past(s_q.st) == NCFG_ST_DIVRST)
            |-> $past(s_q.cnt) == `NCFG_DIVRST_CYC - 4'h1;
    endproperty
    a_divLen: assert property (p_divLen) else $error("divider reset length wrong");
endmodule
`default_nettype wire

// ---- bench/ncfg_host.sv ----
// Host controller model that issues single-byte register accesses
`timescale 1ns/1ps
`default_nettype none
`include "ncfg_map.svh"
module ncfg_host (
    // Clock
    input wire logic clk,
    // Request from the bench
    input wire logic go,
    input wire logic wr,
    input wire logic [`NCFG_AW-1:0] addr,
    input wire logic [`NCFG_DW-1:0] data,
    // Register port
    output logic regWrEn,
    output logic [`NCFG_AW-1:0] regAddr,
    output logic [`NCFG_DW-1:0] regWrData,
    output logic [1:0] commits
);
    // Known start so the first edge has defined lines
    initial begin
        regWrEn = 1'b0;
        regAddr = 4'h0;
        regWrData = 8'h00;
        commits = 2'h0;
    end
    // Idle data toggles so a stale byte never looks valid
    always @(posedge clk) begin
        regWrEn <= go & wr;
        if (go) begin
            regAddr <= addr;
            regWrData <= data;
        end else begin
            regWrData <= ~regWrData;
        end
    end
    // Commit tally; a real host stops at two
    always @(posedge clk) begin
        if (go && wr && addr == 4'h0 && data[1] && commits != 2'h2) begin
            commits <= commits + 2'h1;
        end
    end
endmodule
`default_nettype wire

// ---- bench/nvm_config_and_host_select_tb.sv ----
// Self-checking bench for the configuration loader
`timescale 1ns/1ps
`default_nettype none
`include "ncfg_map.svh"
module nvm_config_and_host_select_tb;
    logic clk, rst_n, pinRst_n, hostSel, w3, go, wr, nvmWrEn, factImg, firstW3;
    logic [3:0] addr, nvmWrAddr;
    logic [7:0] data, nvmWrData, regRdData, pwrIn, pwrOut, pwrLoop;
    logic regWrEn, loadDone, divReset, i2cSel, spi3, commitRefused;
    logic [3:0] regAddr;
    logic [7:0] regWrData;
    logic [1:0] imagesUsed, commits;
    logic [31:0] seed;
    logic [7:0] expQ[$];
    int kindQ[$];
    int n_errors, cmp_count, cyc, i;
    string names[10] = '{"rd", "div", "done", "i2c", "spi3", "img", "refuse", "pin", "pout", "ploop"};

    ncfg_host host_u (.clk(clk), .go(go), .wr(wr), .addr(addr), .data(data),
        .regWrEn(regWrEn), .regAddr(regAddr), .regWrData(regWrData), .commits(commits));
    ncfg_loader dut_u (.clk(clk), .rst_n(rst_n), .clkEn(1'b1), .external_reset_pin_n(pinRst_n),
        .hostSelI2cPin(hostSel), .spi3WirePin(w3), .regWrEn(regWrEn), .regAddr(regAddr),
        .regWrData(regWrData), .regRdData(regRdData), .nvmWrEn(nvmWrEn), .nvmWrAddr(nvmWrAddr),
        .nvmWrData(nvmWrData), .factoryImage(factImg), .loadDone(loadDone), .divReset(divReset),
        .i2cSelected(i2cSel), .spi3Wire(spi3), .imagesUsed(imagesUsed),
        .commitRefused(commitRefused), .pwrDownIn(pwrIn), .pwrDownOut(pwrOut),
        .pwrDownLoop(pwrLoop));

    // Clock at 40 MHz
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    function automatic logic [31:0] lfsr(logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    function automatic logic [7:0] obs(int k);
        case (k)
            0: return regRdData;
            1: return {7'h0, divReset};
            2: return {7'h0, loadDone};
            3: return {7'h0, i2cSel};
            4: return {7'h0, spi3};
            5: return {6'h0, imagesUsed};
            6: return {7'h0, commitRefused};
            7: return pwrIn;
            8: return pwrOut;
            default: return pwrLoop;
        endcase
    endfunction
    task automatic check(string nm, logic [7:0] e, logic [7:0] s);
        cmp_count++;
        if (s !== e) begin
            n_errors++;
            $display("ERROR %s expected %h seen %h", nm, e, s);
        end
    endtask
    task automatic expect_(int k, logic [7:0] v);
        kindQ.push_back(k);
        expQ.push_back(v);
    endtask
    // Monitor takes every pending note, oldest first, once outputs have settled
    always @(negedge clk) begin : mon
        int k;
        logic [7:0] e;
        while (expQ.size() > 0) begin
            k = kindQ.pop_front();
            e = expQ.pop_front();
            check(names[k], e, obs(k));
        end
    end
    task automatic tick(int n);
        repeat (n) @(posedge clk);
    endtask
    // Access through the host; ends two edges after the write is taken
    task automatic wreg(logic [3:0] a, logic [7:0] d, logic w);
        @(posedge clk);
        go <= 1'b1;
        wr <= w;
        addr <= a;
        data <= d;
        @(posedge clk);
        go <= 1'b0;
        tick(3);
    endtask
    task automatic pwr_on(logic sel, logic three, logic fact);
        @(posedge clk);
        rst_n <= 1'b0;
        hostSel <= sel;
        w3 <= three;
        factImg <= fact;
        tick(5);
        expect_(1, 8'h01);
        expect_(2, 8'h00);
        rst_n <= 1'b1;
        tick(20);
        expect_(1, 8'h01);
        for (int j = 0; j < 40 && loadDone !== 1'b1; j++) @(posedge clk);
        expect_(2, 8'h01);
        expect_(1, 8'h00);
        expect_(3, {7'h0, sel});
        expect_(7, fact ? 8'h00 : 8'hff);
    endtask
    task automatic final_report();
        $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
        if (n_errors == 0 && cmp_count > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    // Cut a hang short
    always @(posedge clk) begin
        cyc++;
        if (cyc == 3000) begin
            n_errors++;
            final_report();
        end
    end
    initial begin
        {rst_n, pinRst_n, hostSel, w3, go, wr, nvmWrEn} = 7'b0100000;
        {addr, nvmWrAddr, data, nvmWrData} = 24'h000000;
        n_errors = 0;
        cmp_count = 0;
        cyc = 0;
        factImg = 1'b1;
        seed = lfsr(32'h2ef6);
        firstW3 = seed[0];
        pwr_on(1'b0, seed[0], 1'b1);
        expect_(4, {7'h0, seed[0]});
        // Random power-down masks, then read back
        for (i = 1; i <= 3; i++) begin
            seed = lfsr(lfsr(lfsr(seed)));
            wreg(i[3:0], seed[7:0], 1'b1);
            expect_(6 + i, seed[7:0]);
            wreg(i[3:0], 8'h00, 1'b0);
            expect_(0, seed[7:0]);
        end
        // Hard reset bit, then pin reset
        wreg(4'h0, 8'h01, 1'b1);
        expect_(1, 8'h01);
        tick(10);
        expect_(1, 8'h00);
        expect_(2, 8'h01);
        pinRst_n <= 1'b0;
        tick(3);
        pinRst_n <= 1'b1;
        tick(2);
        expect_(1, 8'h01);
        tick(14);
        expect_(1, 8'h00);
        // Three commits; only two may land
        for (i = 1; i <= 3; i++) begin
            seed = lfsr(seed);
            @(posedge clk);
            nvmWrEn <= 1'b1;
            nvmWrAddr <= seed[3:0];
            nvmWrData <= seed[11:4];
            @(posedge clk);
            nvmWrEn <= 1'b0;
            wreg(4'h0, 8'h02, 1'b1);
            tick(2);
            expect_(5, (i > 2) ? 8'h02 : i[7:0]);
            expect_(6, {7'h0, i == 3});
        end
        check("commits", 8'h02, {6'h0, commits});
        // Blank store with I2C strap: the 3-wire pin must not leak through
        pwr_on(1'b1, 1'b1, 1'b0);
        expect_(4, 8'h00);
        // The other SPI variant from the first power-up
        pwr_on(1'b0, ~firstW3, 1'b1);
        expect_(4, {7'h0, ~firstW3});
        tick(2);
        final_report();
    end
endmodule
`default_nettype wire
